//--- hdl/ifb_defines.vh
// Purpose: constants for the interrupt flag and enable bank
// Assumes: word-aligned 32-bit register bus, 16-bit registers in low half
// Notes: masks give the implemented bit positions of each register
`ifndef IFB_DEFINES_VH
`define IFB_DEFINES_VH

`define IFB_NUM_REGS 9
`define IFB_IDX_W 4
`define IFB_ADDR_W 6

`define IFB_OFS_FLAGS0 6'h00
`define IFB_OFS_FLAGS1 6'h04
`define IFB_OFS_FLAGS3 6'h08
`define IFB_OFS_FLAGS4 6'h0C
`define IFB_OFS_ENABLES0 6'h10
`define IFB_OFS_PRIO0 6'h14
`define IFB_OFS_PRIO1 6'h18
`define IFB_OFS_PRIO2 6'h1C
`define IFB_OFS_PRIO3 6'h20

`define IFB_MASK_FLAGS0 16'h3FEF
`define IFB_MASK_FLAGS1 16'h20DB
`define IFB_MASK_FLAGS3 16'h8600
`define IFB_MASK_FLAGS4 16'h0602
`define IFB_MASK_ENABLES0 16'h3FEF
`define IFB_MASK_PRIO 16'h7777

`define IFB_RST_FLAGS 16'h0000
`define IFB_RST_ENABLES 16'h0000
`define IFB_RST_PRIO 16'h4444

`define IFB_BIT_CAPTURE1 1
`define IFB_BIT_EXT_PIN0 0
`define IFB_BIT_EXT_PIN2 13
`define IFB_BIT_CAPTURE8 7
`define IFB_BIT_CAPTURE7 6
`define IFB_BIT_EXT_PIN1 4
`define IFB_BIT_PIN_CHANGE 3
`define IFB_BIT_I2C_MASTER 1
`define IFB_BIT_I2C_SLAVE 0
`define IFB_BIT_PWM_A_FAULT 15
`define IFB_BIT_POS_DECODER 10
`define IFB_BIT_PWM_A 9
`define IFB_BIT_PWM_B_FAULT 10
`define IFB_BIT_PWM_B_ERROR 9
`define IFB_BIT_UART_ERROR 1

`define IFB_PRIO_OFF 3'h0

`endif

//--- hdl/ifb_reg16.v
// Purpose: one 16-bit software register with hardware set inputs
// Assumes: write and set come from the same clock domain
// Notes: unimplemented bits are held at zero by the mask
`timescale 1ns/1ns
`default_nettype none

module ifb_reg16 #(
  parameter [15:0] MASK = 16'hFFFF,
  parameter [15:0] RESET = 16'h0000
) (
  input wire clk_sys,
  input wire resetn,
  input wire wr_en,
  input wire [15:0] wdata,
  input wire [15:0] set,
  output wire [15:0] next_q,
  output reg [15:0] q
);

  // Set beats a clearing write in the same cycle
  assign next_q = ((wr_en ? wdata : q) | set) & MASK;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= RESET & MASK;
    end else begin
      q <= next_q;
    end
  end

endmodule

`default_nettype wire

//--- hdl/ifb_top.v
// Purpose: interrupt flag, enable and priority registers on AHB-Lite
// Assumes: single slave, zero wait states, word transfers only
// Notes: read data are the value the register takes at the address edge
`timescale 1ns/1ns
`default_nettype none
`include "ifb_defines.vh"

module ifb_top (
  input wire clk_sys,
  input wire resetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [15:0] src_event0,
  input wire [13:0] src_other0,
  input wire capture1_event,
  input wire ext_pin0_event,
  input wire ext_pin2_event,
  input wire capture8_event,
  input wire capture7_event,
  input wire ext_pin1_event,
  input wire pin_change_event,
  input wire i2c_master_event,
  input wire i2c_slave_event,
  input wire pwm_a_fault_event,
  input wire position_decoder_event,
  input wire pwm_a_event,
  input wire pwm_b_fault_event,
  input wire pwm_b_error_event,
  input wire uart_error_event,
  output reg [15:0] flags0,
  output reg [15:0] flags1,
  output reg [15:0] flags3,
  output reg [15:0] flags4,
  output reg [15:0] enables0,
  output reg [15:0] request0,
  output reg [2:0] request_level
);

  localparam NR = `IFB_NUM_REGS;
  localparam [16*9-1:0] MASKS = {
    `IFB_MASK_PRIO, `IFB_MASK_PRIO, `IFB_MASK_PRIO, `IFB_MASK_PRIO,
    `IFB_MASK_ENABLES0, `IFB_MASK_FLAGS4, `IFB_MASK_FLAGS3,
    `IFB_MASK_FLAGS1, `IFB_MASK_FLAGS0};
  localparam [16*9-1:0] RESETS = {
    `IFB_RST_PRIO, `IFB_RST_PRIO, `IFB_RST_PRIO, `IFB_RST_PRIO,
    `IFB_RST_ENABLES, `IFB_RST_FLAGS, `IFB_RST_FLAGS,
    `IFB_RST_FLAGS, `IFB_RST_FLAGS};

  reg wr_pend;
  reg [`IFB_IDX_W-1:0] wr_idx;
  reg [`IFB_IDX_W-1:0] addr_idx;
  reg addr_hit;
  reg [15:0] set0;
  reg [15:0] set1;
  reg [15:0] set3;
  reg [15:0] set4;
  reg [15:0] next_request0;
  reg [2:0] next_level;
  reg [2:0] prio_f;
  reg [15:0] rd_word;
  wire addr_phase;
  wire [16*NR-1:0] set_bus;
  wire [16*NR-1:0] q_bus;
  wire [16*NR-1:0] nq_bus;
  wire [16*4-1:0] prio_bus;
  integer k;

  assign addr_phase = hsel & htrans[1] & hready;

  // Unmapped or misaligned addresses decode to no register
  always @* begin
    addr_hit = 1'b0;
    addr_idx = {`IFB_IDX_W{1'b0}};
    case (haddr[`IFB_ADDR_W-1:0])
      `IFB_OFS_FLAGS0: begin
        addr_hit = 1'b1;
        addr_idx = 4'h0;
      end
      `IFB_OFS_FLAGS1: begin
        addr_hit = 1'b1;
        addr_idx = 4'h1;
      end
      `IFB_OFS_FLAGS3: begin
        addr_hit = 1'b1;
        addr_idx = 4'h2;
      end
      `IFB_OFS_FLAGS4: begin
        addr_hit = 1'b1;
        addr_idx = 4'h3;
      end
      `IFB_OFS_ENABLES0: begin
        addr_hit = 1'b1;
        addr_idx = 4'h4;
      end
      `IFB_OFS_PRIO0: begin
        addr_hit = 1'b1;
        addr_idx = 4'h5;
      end
      `IFB_OFS_PRIO1: begin
        addr_hit = 1'b1;
        addr_idx = 4'h6;
      end
      `IFB_OFS_PRIO2: begin
        addr_hit = 1'b1;
        addr_idx = 4'h7;
      end
      `IFB_OFS_PRIO3: begin
        addr_hit = 1'b1;
        addr_idx = 4'h8;
      end
      default: begin
        addr_hit = 1'b0;
        addr_idx = 4'h0;
      end
    endcase
    if (haddr[31:`IFB_ADDR_W] != {(32-`IFB_ADDR_W){1'b0}}) begin
      addr_hit = 1'b0;
    end
  end

  // Hardware sets, one bit per documented source position
  always @* begin
    set0 = src_event0;
    set0[`IFB_BIT_CAPTURE1] = src_event0[`IFB_BIT_CAPTURE1] |
      capture1_event;
    set0[`IFB_BIT_EXT_PIN0] = src_event0[`IFB_BIT_EXT_PIN0] |
      ext_pin0_event;
    set1 = 16'h0000;
    set1[`IFB_BIT_EXT_PIN2] = ext_pin2_event;
    set1[`IFB_BIT_CAPTURE8] = capture8_event;
    set1[`IFB_BIT_CAPTURE7] = capture7_event;
    set1[`IFB_BIT_EXT_PIN1] = ext_pin1_event;
    set1[`IFB_BIT_PIN_CHANGE] = pin_change_event;
    set1[`IFB_BIT_I2C_MASTER] = i2c_master_event;
    set1[`IFB_BIT_I2C_SLAVE] = i2c_slave_event;
    set3 = 16'h0000;
    set3[`IFB_BIT_PWM_A_FAULT] = pwm_a_fault_event;
    set3[`IFB_BIT_POS_DECODER] = position_decoder_event;
    set3[`IFB_BIT_PWM_A] = pwm_a_event;
    set4 = 16'h0000;
    set4[`IFB_BIT_PWM_B_FAULT] = pwm_b_fault_event;
    set4[`IFB_BIT_PWM_B_ERROR] = pwm_b_error_event;
    set4[`IFB_BIT_UART_ERROR] = uart_error_event;
  end

  // Extra sources of the first bank beyond the two named ones
  assign set_bus = {64'h0, 16'h0000, set4, set3, set1,
    set0 | {2'b00, src_other0[13:5], 1'b0, src_other0[3:2], 2'b00}};

  genvar g;
  generate
    for (g = 0; g < NR; g = g + 1) begin : gen_reg
      ifb_reg16 #(
        .MASK(MASKS[g*16 +: 16]),
        .RESET(RESETS[g*16 +: 16])
      ) u_reg (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .wr_en(wr_pend && (wr_idx == g)),
        .wdata(hwdata[15:0]),
        .set(set_bus[g*16 +: 16]),
        .next_q(nq_bus[g*16 +: 16]),
        .q(q_bus[g*16 +: 16])
      );
    end
  endgenerate

  assign prio_bus = q_bus[16*NR-1:16*5];

  // Flag, enable and a live priority gate each source of the first bank
  always @* begin
    next_level = `IFB_PRIO_OFF;
    next_request0 = 16'h0000;
    prio_f = `IFB_PRIO_OFF;
    for (k = 0; k < 16; k = k + 1) begin
      prio_f = prio_bus[k*4 +: 3];
      next_request0[k] = q_bus[k] & q_bus[64 + k] &
        (prio_f != `IFB_PRIO_OFF);
      if (next_request0[k] && (prio_f > next_level)) begin
        next_level = prio_f;
      end
    end
  end

  // Read returns the value the register holds after this edge
  always @* begin
    rd_word = 16'h0000;
    if (addr_hit) begin
      rd_word = nq_bus[addr_idx*16 +: 16];
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_pend <= 1'b0;
      wr_idx <= {`IFB_IDX_W{1'b0}};
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= addr_phase & hwrite & addr_hit;
      if (addr_phase) begin
        wr_idx <= addr_idx;
      end
      if (addr_phase && !hwrite) begin
        hrdata <= {16'h0000, rd_word};
      end
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flags0 <= `IFB_RST_FLAGS;
      flags1 <= `IFB_RST_FLAGS;
      flags3 <= `IFB_RST_FLAGS;
      flags4 <= `IFB_RST_FLAGS;
      enables0 <= `IFB_RST_ENABLES;
      request0 <= 16'h0000;
      request_level <= `IFB_PRIO_OFF;
    end else begin
      // Mirrors lag the registers by one cycle to keep outputs on flops
      flags0 <= q_bus[15:0];
      flags1 <= q_bus[31:16];
      flags3 <= q_bus[47:32];
      flags4 <= q_bus[63:48];
      enables0 <= q_bus[79:64];
      request0 <= next_request0;
      request_level <= next_level;
    end
  end

endmodule

`default_nettype wire

//--- tb/ifb_chk.sv
// Purpose: port checks on flags, enables and requests
// Assumes: one clock domain, mirrors lag an event by two edges
// Notes: bus timing is judged by the bench
`timescale 1ns/1ns
`default_nettype none
module ifb_chk (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [31:0] hrdata,
  input wire logic capture1_event,
  input wire logic ext_pin2_event,
  input wire logic pwm_a_fault_event,
  input wire logic uart_error_event,
  input wire logic [15:0] flags0,
  input wire logic [15:0] flags1,
  input wire logic [15:0] flags3,
  input wire logic [15:0] flags4,
  input wire logic [15:0] enables0,
  input wire logic [15:0] request0,
  input wire logic [2:0] request_level
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_CAP1_SET: assert property (capture1_event |-> ##2 flags0[1])
    else $error("capture1 flag missed");
  AST_PIN2_SET: assert property (ext_pin2_event |-> ##2 flags1[13])
    else $error("pin2 flag missed");
  AST_FLT_SET: assert property (pwm_a_fault_event |-> ##2 flags3[15])
    else $error("pwm fault flag missed");
  AST_UART_SET: assert property (uart_error_event |-> ##2 flags4[1])
    else $error("uart flag missed");
  AST_UNUSED_ZERO: assert property (
    ((flags0 | enables0) & 16'hC010) == 16'h0 && (flags1 & 16'hDF24) == 16'h0
    && (flags3 & 16'h79FF) == 16'h0 && (flags4 & 16'hF9FD) == 16'h0)
    else $error("unused bit set");
  AST_REQ_GATED: assert property (
    (request0 & ~(flags0 & enables0)) == 16'h0)
    else $error("request without flag and enable");
  AST_LEVEL_IDLE: assert property (
    request0 == 16'h0 && $past(request0) == 16'h0 |-> request_level == 3'h0)
    else $error("level without request");
  AST_HRDATA_HIGH: assert property (hrdata[31:16] == 16'h0)
    else $error("upper read half set");
  cover property (request0 != 16'h0);
  cover property (request_level == 3'h7);
  cover property (flags4[1]);
endmodule
bind ifb_top ifb_chk u_chk (.clk_sys, .resetn, .hrdata, .capture1_event,
  .ext_pin2_event, .pwm_a_fault_event, .uart_error_event, .flags0, .flags1,
  .flags3, .flags4, .enables0, .request0, .request_level);
`default_nettype wire

//--- tb/ifb_src_model.sv
// Purpose: peripheral sources raising requests
// Assumes: bench sets fire for one cycle per request
// Notes: one-cycle pulses, the harder case for capture
`timescale 1ns/1ns
`default_nettype none
module ifb_src_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [44:0] fire,
  output logic [44:0] e
);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      e <= 45'h0;
    end else begin
      e <= fire;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench for the flag and enable bank
// Assumes: AHB-Lite single slave, word accesses
// Notes: sources come from ifb_src_model
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb;
  logic clk_sys = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp;
  logic [44:0] fire = 45'h0, e;
  logic [15:0] request0;
  logic [2:0] request_level;
  int fails = 0, total_checks = 0;
  logic [15:0] ev_val [30:44] = '{16'h0002, 16'h0001, 16'h2000, 16'h0080,
    16'h0040, 16'h0010, 16'h0008, 16'h0002, 16'h0001, 16'h8000, 16'h0400,
    16'h0200, 16'h0400, 16'h0200, 16'h0002};
  ifb_top DUT (.clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .src_event0(e[15:0]), .src_other0(e[29:16]), .capture1_event(e[30]),
    .ext_pin0_event(e[31]), .ext_pin2_event(e[32]), .capture8_event(e[33]),
    .capture7_event(e[34]), .ext_pin1_event(e[35]),
    .pin_change_event(e[36]), .i2c_master_event(e[37]),
    .i2c_slave_event(e[38]), .pwm_a_fault_event(e[39]),
    .position_decoder_event(e[40]), .pwm_a_event(e[41]),
    .pwm_b_fault_event(e[42]), .pwm_b_error_event(e[43]),
    .uart_error_event(e[44]), .flags0(), .flags1(), .flags3(), .flags4(),
    .enables0(), .request0, .request_level);
  ifb_src_model src (.clk_sys, .resetn, .fire, .e);
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    int n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        fails++;
        test_done();
      end
      @(posedge clk_sys);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask
  task automatic pulse(input logic [44:0] v);
    fire <= v;
    @(posedge clk_sys);
    fire <= 45'h0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic t_map();
    logic [31:0] m [5] = '{32'h3FEF, 32'h20DB, 32'h8600, 32'h0602, 32'h3FEF};
    for (logic [31:0] a = 0; a <= 32'h40; a += 4) begin
      xfer(1'b0, a, 32'h0);
      `CHK(rd, (a >= 32'h14 && a <= 32'h20) ? 32'h4444 : 32'h0)
      xfer(1'b1, a, 32'hFFFF_FFFF);
      xfer(1'b0, a, 32'h0);
      if (a < 32'h14) `CHK(rd, m[a / 4])
      if (a >= 32'h14 && a <= 32'h20) `CHK(rd, 32'h7777)
      if (a > 32'h20) `CHK(rd, 32'h0)
      // Priorities go back to their reset level for the request test
      if (a <= 32'h20) xfer(1'b1, a, (a >= 32'h14) ? 32'h4444 : 32'h0);
    end
    $display("test map done");
  endtask
  task automatic t_events();
    logic [31:0] a;
    for (int i = 30; i < 45; i++) begin
      a = i < 32 ? 32'h0 : i < 39 ? 32'h4 : i < 42 ? 32'h8 : 32'hC;
      pulse(45'h1 << i);
      xfer(1'b0, a, 32'h0);
      `CHK(rd, {16'h0, ev_val[i]})
      xfer(1'b1, a, 32'h0);
      xfer(1'b0, a, 32'h0);
      `CHK(rd, 32'h0)
    end
    pulse(45'h3FFF_FFFF);
    xfer(1'b0, 32'h0, 32'h0);
    `CHK(rd, 32'h3FEF)
    xfer(1'b1, 32'h0, 32'h0);
    $display("test events done");
  endtask
  task automatic t_request();
    xfer(1'b1, 32'h10, 32'h2);
    pulse(45'h3 << 30);
    repeat (2) @(posedge clk_sys);
    `CHK(request0, 16'h0002)
    `CHK(request_level, 3'h4)
    xfer(1'b1, 32'h14, 32'h70);
    repeat (3) @(posedge clk_sys);
    `CHK(request_level, 3'h7)
    xfer(1'b1, 32'h14, 32'h0);
    repeat (3) @(posedge clk_sys);
    `CHK(request0, 16'h0)
    xfer(1'b1, 32'h14, 32'h44);
    xfer(1'b1, 32'h10, 32'h1);
    repeat (3) @(posedge clk_sys);
    `CHK(request0, 16'h0001)
    $display("test request done");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_map();
    t_events();
    t_request();
    test_done();
  end
endmodule
`default_nettype wire
